// File: spx_pkg.sv
package spx_pkg;
  localparam logic [7:0] OPC_PUSH_DIR = 8'h70;
  localparam logic [7:0] OPC_PUSH_IND = 8'h71;
  localparam logic [7:0] OPC_USER_PUSH_DEC = 8'h82;
  localparam logic [7:0] OPC_USER_PUSH_INC = 8'h83;
  localparam logic [7:0] OPC_USER_POP_INC = 8'h93;
  localparam logic [3:0] INSTR_CYCLES = 4'h8;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_PTR = 4'h1,
    ST_RD_SRC = 4'h2,
    ST_RD_IND = 4'h3,
    ST_ADJ = 4'h4,
    ST_WR_DATA = 4'h5,
    ST_WR_PTR = 4'h6,
    ST_RD_STK = 4'h7,
    ST_WAIT = 4'h8
  } spx_state_e;
endpackage

// File: spx_rf_if.sv
`timescale 1ns/1ps
`default_nettype none
// Register file port shared by the sequencer and the file itself
interface spx_rf_if;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  modport seq (output raddr, output we, output waddr, output wdata,
    input rdata);
  modport mem (input raddr, input we, input waddr, input wdata,
    output rdata);
endinterface
`default_nettype wire

// File: spx_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// On-chip register file holding user stacks, their pointers and the
// push sources; system stack writes go out on the stack port instead;
// combinational read, clocked write
module spx_regfile #(
  parameter int DEPTH = 256
) (
  input wire logic i_core_clk,
  spx_rf_if.mem rf
);
  logic [7:0] mem [DEPTH];

  initial
  begin
    if (DEPTH != 256)
      $error("spx_regfile: DEPTH must be 256");
  end

  assign rf.rdata = mem[rf.raddr];

  always_ff @(posedge i_core_clk)
  begin
    if (rf.we)
      mem[rf.waddr] <= rf.wdata;
  end
endmodule
`default_nettype wire

// File: spx_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Incrementing user pop copies pointed byte to destination, then bumps pointer.
// - Opcode 93 is three bytes, eight cycles: pointer register, then destination.
// - None of these instructions changes any flag bit.
// - System push decrements stack pointer first, then writes source at new top.
// - Opcode 70 pushes a direct source, two bytes, eight cycles.
// - Opcode 71 pushes a source fetched indirectly, two bytes, eight cycles.
// - Stack pointer is one 16-bit value; decrement from zero wraps to FFFF.
// - Decrementing user push subtracts one from pointer, then writes source there.
// - Opcode 82 is three bytes, eight cycles: pointer register, then source.
// - Incrementing user push adds one to pointer, then writes source there.
// - User stacks and pointers live in the ordinary register file.
module spx_exec (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_op1,
  input wire logic [7:0] i_op2,
  input wire logic [7:0] i_flags,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [15:0] o_stack_addr,
  output logic o_stack_we,
  output logic [7:0] o_stack_wdata,
  output logic [7:0] o_stack_pointer_high,
  output logic [7:0] o_stack_pointer_low,
  output logic [7:0] o_flags
);
  typedef struct packed {
    spx_pkg::spx_state_e st;
    logic [3:0] cnt;
    logic [7:0] opc;
    logic [7:0] ptr_reg;
    logic [7:0] other;
    logic [7:0] ptr_val;
    logic [7:0] data;
    logic [15:0] sp;
    logic busy;
    logic done;
    logic illegal;
    logic [15:0] stk_addr;
    logic stk_we;
    logic [7:0] stk_wdata;
    logic [7:0] flags;
  } spx_state_s;

  spx_state_s s_reg;
  spx_state_s s_next;
  spx_rf_if rf ();

  spx_regfile #(.DEPTH(256)) u_rf (
    .i_core_clk(i_core_clk),
    .rf(rf)
  );

  function automatic logic is_user(input logic [7:0] op);
    is_user = (op == spx_pkg::OPC_USER_PUSH_DEC) ||
      (op == spx_pkg::OPC_USER_PUSH_INC) ||
      (op == spx_pkg::OPC_USER_POP_INC);
  endfunction

  function automatic logic is_sys(input logic [7:0] op);
    is_sys = (op == spx_pkg::OPC_PUSH_DIR) ||
      (op == spx_pkg::OPC_PUSH_IND);
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.illegal = 1'b0;
    s_next.stk_we = 1'b0;
    rf.raddr = s_reg.ptr_reg;
    rf.we = 1'b0;
    rf.waddr = s_reg.ptr_val;
    rf.wdata = s_reg.data;
    if (s_reg.st != spx_pkg::ST_IDLE)
      s_next.cnt = s_reg.cnt + 4'h1;
    case (s_reg.st)
      spx_pkg::ST_IDLE:
      begin
        s_next.cnt = 4'h1;
        if (i_start)
        begin
          s_next.opc = i_opcode;
          s_next.ptr_reg = i_op1;
          s_next.other = i_op2;
          if (is_user(i_opcode))
          begin
            s_next.busy = 1'b1;
            s_next.st = spx_pkg::ST_RD_PTR;
          end
          else if (is_sys(i_opcode))
          begin
            s_next.busy = 1'b1;
            s_next.st = spx_pkg::ST_RD_SRC;
          end
          else
            s_next.illegal = 1'b1;
        end
      end
      spx_pkg::ST_RD_PTR:
      begin
        // Pointer is a plain register-file byte
        rf.raddr = s_reg.ptr_reg;
        s_next.ptr_val = rf.rdata;
        s_next.st = (s_reg.opc == spx_pkg::OPC_USER_POP_INC) ?
          spx_pkg::ST_RD_STK : spx_pkg::ST_RD_SRC;
      end
      spx_pkg::ST_RD_STK:
      begin
        rf.raddr = s_reg.ptr_val;
        rf.we = 1'b1;
        rf.waddr = s_reg.other;
        rf.wdata = rf.rdata; // Copy before pointer moves
        s_next.st = spx_pkg::ST_ADJ;
      end
      spx_pkg::ST_RD_SRC:
      begin
        // System push: operand is the source; user push: third byte
        rf.raddr = is_sys(s_reg.opc) ? s_reg.ptr_reg : s_reg.other;
        s_next.data = rf.rdata;
        s_next.st = (s_reg.opc == spx_pkg::OPC_PUSH_IND) ?
          spx_pkg::ST_RD_IND : spx_pkg::ST_ADJ;
      end
      spx_pkg::ST_RD_IND:
      begin
        rf.raddr = s_reg.data;
        s_next.data = rf.rdata;
        s_next.st = spx_pkg::ST_ADJ;
      end
      spx_pkg::ST_ADJ:
      begin
        if (is_sys(s_reg.opc))
        begin
          s_next.sp = s_reg.sp - spx_pkg::ONE_WORD;
          s_next.st = spx_pkg::ST_WR_DATA;
        end
        else
        begin
          // 8-bit wrap, neighbours untouched
          if (s_reg.opc == spx_pkg::OPC_USER_PUSH_DEC)
            s_next.ptr_val = s_reg.ptr_val - spx_pkg::ONE_BYTE;
          else
            s_next.ptr_val = s_reg.ptr_val + spx_pkg::ONE_BYTE;
          s_next.st = spx_pkg::ST_WR_PTR;
        end
      end
      spx_pkg::ST_WR_PTR:
      begin
        rf.we = 1'b1;
        rf.waddr = s_reg.ptr_reg;
        rf.wdata = s_reg.ptr_val;
        s_next.st = (s_reg.opc == spx_pkg::OPC_USER_POP_INC) ?
          spx_pkg::ST_WAIT : spx_pkg::ST_WR_DATA;
      end
      spx_pkg::ST_WR_DATA:
      begin
        if (is_sys(s_reg.opc))
        begin
          // Stack may be external, so it goes out on the stack port
          s_next.stk_we = 1'b1;
          s_next.stk_addr = s_reg.sp;
          s_next.stk_wdata = s_reg.data;
        end
        else
        begin
          rf.we = 1'b1;
          rf.waddr = s_reg.ptr_val;
          rf.wdata = s_reg.data;
        end
        s_next.st = spx_pkg::ST_WAIT;
      end
      spx_pkg::ST_WAIT:
      begin
        if (s_reg.cnt == spx_pkg::INSTR_CYCLES)
        begin
          s_next.st = spx_pkg::ST_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
      default:
        s_next.st = spx_pkg::ST_IDLE;
    endcase
    // Flags pass through untouched by every instruction here
    s_next.flags = i_flags;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_reg <= '0;
      s_reg.sp <= spx_pkg::SP_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign o_busy = s_reg.busy;
  assign o_done = s_reg.done;
  assign o_illegal = s_reg.illegal;
  assign o_stack_addr = s_reg.stk_addr;
  assign o_stack_we = s_reg.stk_we;
  assign o_stack_wdata = s_reg.stk_wdata;
  assign o_stack_pointer_high = s_reg.sp[15:8];
  assign o_stack_pointer_low = s_reg.sp[7:0];
  assign o_flags = s_reg.flags;

  // Helper: cycles since start, for timing checks
  logic [3:0] a_len;
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      a_len <= 4'h0;
    else if (i_start && !o_busy)
      a_len <= 4'h0;
    else if (o_busy)
      a_len <= a_len + 4'h1;
  end

  sequence seq_sys_start;
    i_start && !o_busy && is_sys(i_opcode);
  endsequence

  sequence seq_sp_dec;
    ##4 (o_stack_pointer_low == $past(o_stack_pointer_low, 4) - 8'h01);
  endsequence

  a_done_len: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_done |-> a_len == 4'h8)
    else $error("instruction not eight cycles");
  a_sys_decr: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    seq_sys_start |-> seq_sp_dec)
    else $error("push did not decrement stack pointer");
  a_sp_wrap: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    seq_sys_start ##0 (s_reg.sp == 16'h0000)
    |-> ##4 s_reg.sp == 16'hFFFF)
    else $error("stack pointer did not wrap");
  a_push_addr: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_stack_we |-> o_stack_addr == s_reg.sp)
    else $error("push written off new top");
  a_push_time: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    seq_sys_start |-> ##[4:5] o_stack_we ##[4:5] o_done)
    else $error("push sequence mistimed");
  a_flag_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    $past(i_rstn) |-> o_flags == $past(i_flags))
    else $error("flags altered");
  a_user_ptr: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (s_reg.st == spx_pkg::ST_ADJ && is_user(s_reg.opc))
    |=> s_reg.ptr_val == $past(s_reg.ptr_val) +
    ((s_reg.opc == spx_pkg::OPC_USER_PUSH_DEC) ? 8'hFF : 8'h01))
    else $error("user pointer step wrong");
  a_pop_order: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_reg.st == spx_pkg::ST_RD_STK |=> s_reg.st == spx_pkg::ST_ADJ
    ##1 s_reg.st == spx_pkg::ST_WR_PTR)
    else $error("pop moved pointer before copy");
  a_upush_order: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (s_reg.st == spx_pkg::ST_WR_PTR && s_reg.opc != spx_pkg::OPC_USER_POP_INC)
    |=> s_reg.st == spx_pkg::ST_WR_DATA)
    else $error("user push wrote before pointer step");
  a_user_start: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_start && !o_busy && is_user(i_opcode) |=> ##8 o_done)
    else $error("user instruction mistimed");
endmodule
`default_nettype wire

// File: stack_push_pop_execute_test.sv
`timescale 1ns/1ps
`default_nettype none
module stack_push_pop_execute_test;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_start = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_op1 = 8'h00;
  logic [7:0] i_op2 = 8'h00;
  logic [7:0] i_flags = 8'hA5;
  logic o_busy;
  logic o_done;
  logic o_illegal;
  logic [15:0] o_stack_addr;
  logic o_stack_we;
  logic [7:0] o_stack_wdata;
  logic [7:0] o_stack_pointer_high;
  logic [7:0] o_stack_pointer_low;
  logic [7:0] o_flags;
  int fail_count = 0;
  int n_compared = 0;
  int cyc;
  int n_we;
  int n_busy;
  int n_ill;
  logic [15:0] we_addr;
  logic [15:0] sp_exp = 16'h0000;

  always #12.5 i_core_clk = ~i_core_clk;

  spx_exec spx_exec_inst (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_start(i_start),
    .i_opcode(i_opcode),
    .i_op1(i_op1),
    .i_op2(i_op2),
    .i_flags(i_flags),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_illegal(o_illegal),
    .o_stack_addr(o_stack_addr),
    .o_stack_we(o_stack_we),
    .o_stack_wdata(o_stack_wdata),
    .o_stack_pointer_high(o_stack_pointer_high),
    .o_stack_pointer_low(o_stack_pointer_low),
    .o_flags(o_flags)
  );

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Start raised again at cycle again must be ignored while busy
  task automatic run(input logic [7:0] opc, input int again);
    cyc = 0;
    n_we = 0;
    n_busy = 0;
    we_addr = 16'h0000;
    i_opcode = opc;
    i_op1 = 8'h10;
    i_op2 = 8'h20;
    i_start = 1'b1;
    @(posedge i_core_clk);
    #2;
    i_start = 1'b0;
    // Illegal pulse stands only in the cycle right after the start edge
    n_ill = (o_illegal === 1'b1) ? 1 : 0;
    repeat (12)
    begin
      @(posedge i_core_clk);
      #2;
      cyc++;
      i_start = (cyc == again);
      check("flags", {8'h00, o_flags}, {8'h00, i_flags});
      if (o_stack_we === 1'b1)
      begin
        n_we++;
        we_addr = o_stack_addr;
      end
      if (o_done === 1'b1 || o_illegal === 1'b1)
        break;
      if (o_busy === 1'b1)
        n_busy++;
    end
    i_start = 1'b0;
  endtask

  function automatic logic [15:0] sp_seen();
    return {o_stack_pointer_high, o_stack_pointer_low};
  endfunction

  task automatic t_reset();
    check("sp", sp_seen(), 16'h0000);
    check("busy", {15'h0000, o_busy}, 16'h0000);
    check("done", {15'h0000, o_done}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_sys_push(input logic [7:0] opc, input int again);
    run(opc, again);
    sp_exp = sp_exp - 16'h0001;
    check("cycles", 16'(cyc), 16'h0008);
    check("busy cycles", 16'(n_busy), 16'h0007);
    check("writes", 16'(n_we), 16'h0001);
    check("write addr", we_addr, sp_exp);
    check("sp", sp_seen(), sp_exp);
    $display("test system push %h done", opc);
  endtask

  task automatic t_user();
    logic [7:0] opcs [3];
    opcs = '{8'h82, 8'h83, 8'h93};
    foreach (opcs[k])
    begin
      i_flags = ~i_flags;
      run(opcs[k], 0);
      check("cycles", 16'(cyc), 16'h0008);
      check("busy cycles", 16'(n_busy), 16'h0007);
      check("writes", 16'(n_we), 16'h0000);
      check("sp", sp_seen(), sp_exp);
    end
    $display("test user stack done");
  endtask

  task automatic t_illegal();
    run(8'h00, 0);
    check("illegal busy", 16'(n_busy), 16'h0000);
    check("illegal", 16'(n_ill), 16'h0001);
    check("writes", 16'(n_we), 16'h0000);
    check("sp", sp_seen(), sp_exp);
    $display("test illegal done");
  endtask

  task automatic t_refuse();
    int extra;
    extra = 0;
    t_sys_push(8'h70, 3);
    repeat (10)
    begin
      @(posedge i_core_clk);
      #2;
      if (o_done === 1'b1 || o_stack_we === 1'b1)
        extra++;
    end
    check("ignored start", 16'(extra), 16'h0000);
    check("sp", sp_seen(), sp_exp);
    $display("test refused start done");
  endtask

  initial
  begin
    repeat (20) @(posedge i_core_clk);
    #2;
    i_rstn = 1'b1;
    t_reset();
    // Back to back from reset: 0000 wraps to FFFF, then FFFE
    t_sys_push(8'h70, 0);
    t_sys_push(8'h71, 0);
    t_user();
    t_illegal();
    t_refuse();
    results();
  end

  initial
  begin
    #(25 * 2000);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
